// file: design/dcms_defs.svh
`ifndef DCMS_DEFS_SVH
`define DCMS_DEFS_SVH

// Register byte offsets
`define DCMS_OFS_CTRL       8'h00
`define DCMS_OFS_STATUS     8'h04
`define DCMS_OFS_SPEED      8'h08
`define DCMS_OFS_PARAM_BASE 8'h0C
`define DCMS_OFS_CFG_BASE   8'h10
`define DCMS_OFS_IRQ_STAT   8'h14
`define DCMS_OFS_IRQ_MASK   8'h18
`define DCMS_OFS_DMA_PERIOD 8'h1C

// Control register fields
`define DCMS_CTRL_PERIPH_RDY 0
`define DCMS_CTRL_MON_START  1
`define DCMS_CTRL_DMA_EN     2

// Interrupt status fields
`define DCMS_IRQ_OVERCUR 0
`define DCMS_IRQ_GLOBAL  1
`define DCMS_IRQ_STATE   2
`define DCMS_IRQ_PWMFAIL 3

// Reset values
`define DCMS_DMA_PERIOD_RST 16'h03E8
`define DCMS_DMEM_BASE_RST  16'h0100

// Speed limits and button step
`define DCMS_SPEED_MAX  16'h0BB8
`define DCMS_SPEED_STEP 16'h0064

// Timing
`define DCMS_CLK_NS        10
`define DCMS_SPEED_UPD_NS  1000000

`endif

// file: design/dcms_pkg.sv
package dcms_pkg;

    // Supervisor states, one-hot
    typedef enum logic [6:0] {
        ST_INIT    = 7'h01,
        ST_STOP    = 7'h02,
        ST_ENABLE  = 7'h04,
        ST_RUN     = 7'h08,
        ST_DISABLE = 7'h10,
        ST_MFAULT  = 7'h20,
        ST_GFAULT  = 7'h40
    } dcms_state_e;

    // Command to the PWM generator
    typedef struct packed {
        logic req;
        logic on;
    } dcms_pwm_cmd_s;

    // Required speed to the loop coprocessor
    typedef struct packed {
        logic wr;
        logic [15:0] speed;
    } dcms_speed_s;

    // Write into coprocessor data memory
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] data;
    } dcms_dmem_wr_s;

    typedef logic [3:0][15:0] dcms_queue_t;

    // Whole block state
    typedef struct packed {
        dcms_state_e state;
        logic pwm_wait;
        dcms_pwm_cmd_s pwm_cmd;
        logic gpio_rise_cfg;
        logic [1:0] sw_sync;
        logic [1:0] up_sync;
        logic [1:0] dn_sync;
        logic up_prev;
        logic dn_prev;
        logic [15:0] speed;
        logic [31:0] spd_cnt;
        dcms_speed_s spd_out;
        logic [2:0] ctrl;
        logic [31:0] param_base;
        logic [31:0] cfg_base;
        logic [1:0] bases_set;
        logic mon_en;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [15:0] dma_period;
        logic [15:0] dma_cnt;
        logic dma_busy;
        logic [1:0] dma_ch;
        dcms_dmem_wr_s dmem;
        logic ack;
        logic [31:0] rdata;
    } dcms_regs_s;

endpackage

// file: design/dcms_supervisor.sv
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
`include "dcms_defs.svh"
// Notes on behaviour
// - In the stopped state all PWM outputs are off while decoder outputs stay visible.
// - Switch on while stopped leads through the enable state toward running.
// - Entering enable clears the required speed and asks the PWM generator to start in the same cycle.
// - On PWM start success the input channel is set to rising-edge interrupt and running begins.
// - On PWM start failure the supervisor stays in enable and asks again.
// - While running PWM stays on and speed follows the buttons or the host.
// - While running the latest required speed is written periodically to the coprocessor.
// - Switch off while running leads through the disable state toward stopped.
// - Entering disable clears the required speed and asks the PWM generator to stop in the same cycle.
// - On PWM stop success the supervisor stops; on failure it stays in disable and retries.
// - A serviced over-current event forces the motor fault state from any state.
// - In motor fault the supervisor waits for switch off, clears the fault and stops.
// - A global exception forces global fault, then switch off clears it and re-initializes.
// - Four transfer channels paced by a timer move converter samples into coprocessor memory.
// - Monitor setup is accepted only after both base pointers have been written.
module dcms_supervisor #(
    parameter int SPEED_UPD_CYC = `DCMS_SPEED_UPD_NS / `DCMS_CLK_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic switch_on_i,
    input wire logic btn_up_i,
    input wire logic btn_down_i,
    input wire logic overcurrent_i,
    input wire logic global_exc_i,
    output dcms_pkg::dcms_pwm_cmd_s pwm_cmd_o,
    input wire logic pwm_ack_i,
    input wire logic pwm_ok_i,
    output logic pwm_out_en_o,
    output logic gpio_rise_cfg_o,
    output dcms_pkg::dcms_speed_s speed_o,
    input wire dcms_pkg::dcms_queue_t qspi_rx_i,
    output dcms_pkg::dcms_dmem_wr_s dmem_o,
    output logic [31:0] param_base_o,
    output logic [31:0] cfg_base_o,
    output logic monitor_en_o,
    output logic fault_o,
    output logic irq_o
);

    // Counter is 32 bits wide
    // A divider below one cycle cannot be counted
    if (SPEED_UPD_CYC < 1) begin : g_chk
        $error("SPEED_UPD_CYC must be at least 1");
    end

    // Last count of the speed update divider
    localparam logic [31:0] UPD_LAST = 32'(SPEED_UPD_CYC - 1);

    // Whole block state in one register, next value beside it
    dcms_pkg::dcms_regs_s r_reg;
    dcms_pkg::dcms_regs_s r_next;

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Saturating speed step, signed
    function automatic logic [15:0] step(input logic [15:0] v, input logic up);
        logic signed [16:0] s;
        // One extra bit so the limit test cannot wrap
        s = up ? $signed({v[15], v}) + $signed({1'b0, `DCMS_SPEED_STEP}) :
                 $signed({v[15], v}) - $signed({1'b0, `DCMS_SPEED_STEP});
        if (s > $signed({1'b0, `DCMS_SPEED_MAX})) begin
            s = $signed({1'b0, `DCMS_SPEED_MAX});
        end
        if (s < -$signed({1'b0, `DCMS_SPEED_MAX})) begin
            s = -$signed({1'b0, `DCMS_SPEED_MAX});
        end
        return s[15:0];
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic sw;
        logic bus_req;
        logic [3:0] clr;
        logic [3:0] ev;
        logic [31:0] wv;
        // Working values, each set before any use
        sw = r_reg.sw_sync[1];
        bus_req = cyc_i & stb_i & ~r_reg.ack;
        clr = 4'h0;
        ev = 4'h0;
        wv = 32'h0;
        // Hold by default; strobes fall back to zero every cycle
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.pwm_cmd.req = 1'b0;
        r_next.spd_out.wr = 1'b0;
        r_next.dmem.wr = 1'b0;

        // Pins cross into the clock domain through two flops
        r_next.sw_sync = {r_reg.sw_sync[0], switch_on_i};
        r_next.up_sync = {r_reg.up_sync[0], btn_up_i};
        r_next.dn_sync = {r_reg.dn_sync[0], btn_down_i};
        r_next.up_prev = r_reg.up_sync[1];
        r_next.dn_prev = r_reg.dn_sync[1];

        // Wishbone slave, ack one cycle after the request
        if (bus_req) begin
            r_next.ack = 1'b1;
            // Read data is registered, so dat_o comes straight from a flop
            case (adr_i)
                `DCMS_OFS_CTRL: r_next.rdata = {29'h0, r_reg.ctrl};
                `DCMS_OFS_STATUS: r_next.rdata = {16'h0, r_reg.mon_en, r_reg.pwm_wait,
                                                  r_reg.gpio_rise_cfg, sw, 5'h0, r_reg.state};
                `DCMS_OFS_SPEED: r_next.rdata = {16'h0, r_reg.speed};
                `DCMS_OFS_PARAM_BASE: r_next.rdata = r_reg.param_base;
                `DCMS_OFS_CFG_BASE: r_next.rdata = r_reg.cfg_base;
                `DCMS_OFS_IRQ_STAT: r_next.rdata = {28'h0, r_reg.irq_stat};
                `DCMS_OFS_IRQ_MASK: r_next.rdata = {28'h0, r_reg.irq_mask};
                `DCMS_OFS_DMA_PERIOD: r_next.rdata = {16'h0, r_reg.dma_period};
                default: r_next.rdata = 32'h0;
            endcase

            // Unmapped offsets are acked and the write is dropped
            if (we_i) begin
                case (adr_i)
                    `DCMS_OFS_CTRL: begin
                        wv = merge({29'h0, r_reg.ctrl}, dat_i, sel_i);
                        r_next.ctrl = wv[2:0];
                        // Host link starts only once it can find the bases
                        if (wv[`DCMS_CTRL_MON_START] && (&r_reg.bases_set)) begin
                            r_next.mon_en = 1'b1;
                        end
                    end
                    `DCMS_OFS_SPEED: begin
                        wv = merge({16'h0, r_reg.speed}, dat_i, sel_i);
                        // Host speed counts only while running
                        if (r_reg.state == dcms_pkg::ST_RUN) begin
                            r_next.speed = wv[15:0];
                        end
                    end
                    // Each base counts as set from its first write on
                    `DCMS_OFS_PARAM_BASE: begin
                        r_next.param_base = merge(r_reg.param_base, dat_i, sel_i);
                        r_next.bases_set[0] = 1'b1;
                    end
                    `DCMS_OFS_CFG_BASE: begin
                        r_next.cfg_base = merge(r_reg.cfg_base, dat_i, sel_i);
                        r_next.bases_set[1] = 1'b1;
                    end
                    // Write one to clear; zero lanes leave bits alone
                    `DCMS_OFS_IRQ_STAT: begin
                        wv = merge(32'h0, dat_i, sel_i);
                        clr = wv[3:0];
                    end
                    `DCMS_OFS_IRQ_MASK: begin
                        wv = merge({28'h0, r_reg.irq_mask}, dat_i, sel_i);
                        r_next.irq_mask = wv[3:0];
                    end
                    // A zero period parks the transfer timer
                    `DCMS_OFS_DMA_PERIOD: begin
                        wv = merge({16'h0, r_reg.dma_period}, dat_i, sel_i);
                        r_next.dma_period = wv[15:0];
                    end
                    default: begin
                        wv = 32'h0;
                    end
                endcase
            end
        end

        // Supervisor sequence
        case (r_reg.state)
            // Waits for software to finish peripheral setup
            dcms_pkg::ST_INIT: begin
                r_next.pwm_wait = 1'b0;
                // Software signals that peripheral setup is done
                if (r_reg.ctrl[`DCMS_CTRL_PERIPH_RDY]) begin
                    r_next.state = dcms_pkg::ST_STOP;
                end
            end

            // Motor unpowered; waits for the synced switch
            dcms_pkg::ST_STOP: begin
                if (sw) begin
                    r_next.state = dcms_pkg::ST_ENABLE;
                    r_next.pwm_wait = 1'b0;
                end
            end

            // First cycle asks, later cycles wait for the answer
            dcms_pkg::ST_ENABLE: begin
                if (!r_reg.pwm_wait) begin
                    r_next.speed = 16'h0000;
                    r_next.pwm_cmd.req = 1'b1;
                    r_next.pwm_cmd.on = 1'b1;
                    r_next.pwm_wait = 1'b1;
                end else if (pwm_ack_i) begin
                    r_next.pwm_wait = 1'b0;
                    if (pwm_ok_i) begin
                        // Input channel armed together with the run entry
                        r_next.gpio_rise_cfg = 1'b1;
                        r_next.state = dcms_pkg::ST_RUN;
                    end else begin
                        // Flagged; the cleared wait bit repeats the request
                        ev[`DCMS_IRQ_PWMFAIL] = 1'b1;
                    end
                end
            end

            // Motor powered; speed follows buttons and host
            dcms_pkg::ST_RUN: begin
                // Buttons step the speed on their press edge
                if (r_reg.up_sync[1] && !r_reg.up_prev) begin
                    r_next.speed = step(r_reg.speed, 1'b1);
                end else if (r_reg.dn_sync[1] && !r_reg.dn_prev) begin
                    r_next.speed = step(r_reg.speed, 1'b0);
                end
                if (!sw) begin
                    r_next.state = dcms_pkg::ST_DISABLE;
                    r_next.pwm_wait = 1'b0;
                end
            end

            // Mirror of enable, asking the generator to stop
            dcms_pkg::ST_DISABLE: begin
                if (!r_reg.pwm_wait) begin
                    r_next.speed = 16'h0000;
                    r_next.pwm_cmd.req = 1'b1;
                    r_next.pwm_cmd.on = 1'b0;
                    r_next.pwm_wait = 1'b1;
                end else if (pwm_ack_i) begin
                    r_next.pwm_wait = 1'b0;
                    if (pwm_ok_i) begin
                        r_next.gpio_rise_cfg = 1'b0;
                        r_next.state = dcms_pkg::ST_STOP;
                    end else begin
                        // Stays here and asks again next cycle
                        ev[`DCMS_IRQ_PWMFAIL] = 1'b1;
                    end
                end
            end

            // Fault clears only once the operator turns the switch off
            dcms_pkg::ST_MFAULT: begin
                if (!sw) begin
                    r_next.state = dcms_pkg::ST_STOP;
                end
            end

            // Same exit, but through init so setup runs again
            dcms_pkg::ST_GFAULT: begin
                if (!sw) begin
                    r_next.state = dcms_pkg::ST_INIT;
                end
            end

            // Illegal code recovers through init
            default: begin
                r_next.state = dcms_pkg::ST_INIT;
            end
        endcase

        // Faults override any sequence step; global wins over over-current
        // A request still out is abandoned; its late answer finds no wait and is ignored
        if (global_exc_i) begin
            r_next.state = dcms_pkg::ST_GFAULT;
            r_next.pwm_wait = 1'b0;
            r_next.gpio_rise_cfg = 1'b0;
            r_next.speed = 16'h0000;
            ev[`DCMS_IRQ_GLOBAL] = 1'b1;
        end else if (overcurrent_i) begin
            r_next.state = dcms_pkg::ST_MFAULT;
            r_next.pwm_wait = 1'b0;
            r_next.gpio_rise_cfg = 1'b0;
            r_next.speed = 16'h0000;
            ev[`DCMS_IRQ_OVERCUR] = 1'b1;
        end

        // Every transition raises the state change event
        if (r_next.state != r_reg.state) begin
            ev[`DCMS_IRQ_STATE] = 1'b1;
        end

        // Periodic speed write while running
        // Restarts on each run entry, so the first write comes a full period in
        if (r_reg.state == dcms_pkg::ST_RUN) begin
            if (r_reg.spd_cnt >= UPD_LAST) begin
                r_next.spd_cnt = 32'h0;
                r_next.spd_out.wr = 1'b1;
                r_next.spd_out.speed = r_reg.speed;
            end else begin
                r_next.spd_cnt = r_reg.spd_cnt + 32'h1;
            end
        end else begin
            r_next.spd_cnt = 32'h0;
        end

        // Transfer timer; a burst of four channels per tick
        if (r_reg.dma_busy) begin
            r_next.dmem.wr = 1'b1;
            // Words land at consecutive addresses from the base
            r_next.dmem.addr = `DCMS_DMEM_BASE_RST + {14'h0, r_reg.dma_ch};
            r_next.dmem.data = qspi_rx_i[r_reg.dma_ch];
            r_next.dma_ch = r_reg.dma_ch + 2'h1;
            if (r_reg.dma_ch == 2'h3) begin
                r_next.dma_busy = 1'b0;
            end
        end

        // Pacing timer; disabled or zero period holds it at zero
        if (!r_reg.ctrl[`DCMS_CTRL_DMA_EN] || r_reg.dma_period == 16'h0000) begin
            r_next.dma_cnt = 16'h0000;
        end else if (r_reg.dma_cnt >= r_reg.dma_period - 16'h0001) begin
            // A tick during a burst is dropped, not queued
            r_next.dma_cnt = 16'h0000;
            if (!r_reg.dma_busy) begin
                r_next.dma_busy = 1'b1;
                r_next.dma_ch = 2'h0;
            end
        end else begin
            r_next.dma_cnt = r_reg.dma_cnt + 16'h0001;
        end

        // Set beats clear in the same cycle
        r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.state <= dcms_pkg::ST_INIT;
            // Only non-zero reset value besides the state
            r_reg.dma_period <= `DCMS_DMA_PERIOD_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    assign dat_o = r_reg.rdata;
    assign ack_o = r_reg.ack;

    // PWM generator side
    assign pwm_cmd_o = r_reg.pwm_cmd;
    assign pwm_out_en_o = (r_reg.state == dcms_pkg::ST_RUN);
    assign gpio_rise_cfg_o = r_reg.gpio_rise_cfg;

    // Coprocessor writes from flops; the speed strobe lasts one cycle, the memory strobe four cycles per burst
    assign speed_o = r_reg.spd_out;
    assign dmem_o = r_reg.dmem;

    // Host link bases and enable
    assign param_base_o = r_reg.param_base;
    assign cfg_base_o = r_reg.cfg_base;
    assign monitor_en_o = r_reg.mon_en;

    // Levels decoded from registered state, so they do not glitch
    assign fault_o = (r_reg.state == dcms_pkg::ST_MFAULT) ||
                     (r_reg.state == dcms_pkg::ST_GFAULT);
    assign irq_o = |(r_reg.irq_stat & r_reg.irq_mask);

endmodule

// file: verification/dcms_assertions.sv
`timescale 1ns/1ns
module dcms_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic switch_on_i,
    input wire logic overcurrent_i,
    input wire logic global_exc_i,
    input wire dcms_pkg::dcms_pwm_cmd_s pwm_cmd_o,
    input wire logic pwm_ack_i,
    input wire logic pwm_ok_i,
    input wire logic pwm_out_en_o,
    input wire logic gpio_rise_cfg_o,
    input wire dcms_pkg::dcms_speed_s speed_o,
    input wire dcms_pkg::dcms_dmem_wr_s dmem_o,
    input wire logic fault_o
);
    // One clock domain, so one default clock and disable
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_one_cycle_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer late or stretched");
    run_entry_a: assert property ($rose(pwm_out_en_o) |-> gpio_rise_cfg_o &&
        $past(pwm_ack_i && pwm_ok_i && pwm_cmd_o.on)) else $error("run entered without success");
    pwm_retry_a: assert property (pwm_ack_i && !pwm_ok_i && !fault_o && !overcurrent_i &&
        !global_exc_i |-> ##2 pwm_cmd_o.req && !pwm_out_en_o) else $error("no retry after failure");
    req_pulse_a: assert property (pwm_cmd_o.req |=> !pwm_cmd_o.req)
        else $error("pwm request longer than one cycle");
    fault_entry_a: assert property ((overcurrent_i || global_exc_i) |=> fault_o &&
        !pwm_out_en_o && !gpio_rise_cfg_o) else $error("fault not entered");
    fault_exit_a: assert property ($fell(fault_o) |-> !$past(switch_on_i, 3))
        else $error("fault cleared with switch on");
    speed_run_a: assert property (speed_o.wr |-> $past(pwm_out_en_o) ##1 !speed_o.wr)
        else $error("speed write outside running");
    dmem_burst_a: assert property ($rose(dmem_o.wr) |-> dmem_o.wr [*4] ##1 !dmem_o.wr)
        else $error("transfer burst not four words");
    dmem_addr_a: assert property (dmem_o.wr |-> dmem_o.addr[15:2] == 14'h0040)
        else $error("transfer address out of range");
endmodule

// file: verification/dcms_pwm_model.sv
`timescale 1ns/1ns
module dcms_pwm_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dcms_pkg::dcms_pwm_cmd_s cmd_i,
    input wire logic fail_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic ok_o
);
    logic busy;
    logic [3:0] cnt;
    // One request at a time; result line wanders when not valid
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        ok_o <= ~ok_o;
        if (rst_i) begin
            busy <= 1'b0;
            ok_o <= 1'b1;
        end else if (cmd_i.req) begin
            busy <= 1'b1;
            cnt <= slow_i ? 4'h6 : 4'h0;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            ack_o <= 1'b1;
            ok_o <= !fail_i;
        end else begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// file: verification/dc_motor_drive_supervisor_test.sv
`timescale 1ns/1ns
module dc_motor_drive_supervisor_test;
    logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, sw, up, dn, oc, ge;
    logic pwm_ack, pwm_ok, pwm_en, gpio, mon_en, fault, irq, fail, slow;
    logic [7:0] adr_i;
    logic [31:0] dat_i, dat_o, q, pbase, cbase;
    logic [3:0] sel_i;
    dcms_pkg::dcms_pwm_cmd_s pwm_cmd;
    dcms_pkg::dcms_speed_s spd;
    dcms_pkg::dcms_dmem_wr_s dmem;
    dcms_pkg::dcms_queue_t rx;
    int n_fail, checked, i;

    dcms_supervisor #(.SPEED_UPD_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .ack_o(ack_o), .switch_on_i(sw), .btn_up_i(up), .btn_down_i(dn),
        .overcurrent_i(oc), .global_exc_i(ge), .pwm_cmd_o(pwm_cmd), .pwm_ack_i(pwm_ack),
        .pwm_ok_i(pwm_ok), .pwm_out_en_o(pwm_en), .gpio_rise_cfg_o(gpio), .speed_o(spd),
        .qspi_rx_i(rx), .dmem_o(dmem), .param_base_o(pbase), .cfg_base_o(cbase),
        .monitor_en_o(mon_en), .fault_o(fault), .irq_o(irq));
    dcms_pwm_model pwm (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(pwm_cmd), .fail_i(fail),
        .slow_i(slow), .ack_o(pwm_ack), .ok_o(pwm_ok));

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic cycle: hold everything until ack is seen at an edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask

    // Poll the state field; bounded so a stuck machine shows up
    task automatic wait_st(input logic [6:0] s);
        int n;
        n = 0;
        do begin
            wb(8'h04, 1'b0, 32'h0);
            n++;
        end while (q[6:0] !== s && n < 40);
        chk({25'h0, q[6:0]}, {25'h0, s});
    endtask

    task automatic press(input bit u);
        up <= u;
        dn <= !u;
        repeat (4) @(posedge clk_i);
        up <= 1'b0;
        dn <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // Waits for one failed answer, then lets the generator succeed
    task automatic fail_once();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pwm_ack !== 1'b1 && n < 80);
        chk({31'h0, pwm_ok}, 32'h0);
        fail <= 1'b0;
    endtask

    task automatic pulse(input bit g);
        @(posedge clk_i);
        oc <= !g;
        ge <= g;
        @(posedge clk_i);
        oc <= 1'b0;
        ge <= 1'b0;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #300000;
        n_fail++;
        close_out();
    end

    initial begin
        {we_i, cyc_i, stb_i, sw, up, dn, oc, ge, fail, slow} = 10'h000;
        adr_i = 8'h00;
        dat_i = 32'h0;
        sel_i = 4'hF;
        rx = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
        n_fail = 0;
        checked = 0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h04, 32'h0000_0001);
        rd(8'h20, 32'h0);
        wb(8'h00, 1'b1, 32'h2);
        chk({31'h0, mon_en}, 32'h0);
        wb(8'h0C, 1'b1, 32'h1234);
        wb(8'h10, 1'b1, 32'h5678);
        wb(8'h00, 1'b1, 32'h3);
        chk({31'h0, mon_en}, 32'h1);
        chk(pbase, 32'h0000_1234);
        chk(cbase, 32'h0000_5678);
        wait_st(7'h02);
        chk({31'h0, pwm_en}, 32'h0);
        fail <= 1'b1;
        slow <= 1'b1;
        sw <= 1'b1;
        fail_once();
        wait_st(7'h08);
        chk({30'h0, gpio, pwm_en}, 32'h3);
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h0000_000C);
        wb(8'h08, 1'b1, 32'h0B54);
        press(1'b1);
        press(1'b1);
        rd(8'h08, 32'h0BB8);
        press(1'b0);
        rd(8'h08, 32'h0B54);
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (spd.wr !== 1'b1 && i < 60);
        chk({31'h0, spd.wr}, 32'h1);
        chk({16'h0, spd.speed}, 32'h0B54);
        chk({31'h0, irq}, 32'h0);
        wb(8'h18, 1'b1, 32'h8);
        chk({31'h0, irq}, 32'h1);
        wb(8'h14, 1'b1, 32'hF);
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        wb(8'h18, 1'b1, 32'h0);
        wb(8'h1C, 1'b1, 32'h10);
        wb(8'h00, 1'b1, 32'h7);
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (dmem.wr !== 1'b1 && i < 60);
        for (i = 0; i < 4; i++) begin
            chk({dmem.addr, dmem.data}, {14'h0040, i[1:0], rx[i]});
            @(posedge clk_i);
        end
        wb(8'h00, 1'b1, 32'h3);
        fail <= 1'b1;
        slow <= 1'b0;
        sw <= 1'b0;
        fail_once();
        wait_st(7'h02);
        rd(8'h08, 32'h0);
        wb(8'h08, 1'b1, 32'h0100);
        rd(8'h08, 32'h0);
        sw <= 1'b1;
        wait_st(7'h08);
        pulse(1'b0);
        repeat (10) @(posedge clk_i);
        chk({31'h0, fault}, 32'h1);
        wait_st(7'h20);
        sw <= 1'b0;
        wait_st(7'h02);
        chk({31'h0, fault}, 32'h0);
        wb(8'h00, 1'b1, 32'h0);
        sw <= 1'b1;
        wait_st(7'h08);
        pulse(1'b1);
        wait_st(7'h40);
        sw <= 1'b0;
        wait_st(7'h01);
        close_out();
    end
endmodule

bind dcms_supervisor dcms_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .switch_on_i(switch_on_i), .overcurrent_i(overcurrent_i),
    .global_exc_i(global_exc_i), .pwm_cmd_o(pwm_cmd_o), .pwm_ack_i(pwm_ack_i),
    .pwm_ok_i(pwm_ok_i), .pwm_out_en_o(pwm_out_en_o), .gpio_rise_cfg_o(gpio_rise_cfg_o),
    .speed_o(speed_o), .dmem_o(dmem_o), .fault_o(fault_o));
